/* include/gp_consts.vh */
// constants for the five-port gpio bank: offsets, reset vectors, widths
`ifndef GP_CONSTS_VH
`define GP_CONSTS_VH

`define GP_NPORT        5
`define GP_PW           8
`define GP_ALLW         40
`define GP_FCW          4

// byte address fields: port select and in-port offset
`define GP_PORT_HI      14
`define GP_PORT_LO      12
`define GP_OFF_HI       11
`define GP_ADR_W        16

// data window 0x000..0x3FC, mask taken from address bits 9:2
`define GP_DATA_WIN     2'h0
`define GP_OFF_DIR      12'h400
`define GP_OFF_ISENSE   12'h404
`define GP_OFF_IBOTH    12'h408
`define GP_OFF_IEVT     12'h40C
`define GP_OFF_IMASK    12'h410
`define GP_OFF_RAW      12'h414
`define GP_OFF_MSTAT    12'h418
`define GP_OFF_ICLR     12'h41C
`define GP_OFF_ALTSEL   12'h420
`define GP_OFF_DR2      12'h500
`define GP_OFF_DR4      12'h504
`define GP_OFF_DR8      12'h508
`define GP_OFF_ODRAIN   12'h50C
`define GP_OFF_PULLUP   12'h510
`define GP_OFF_PULLDN   12'h514
`define GP_OFF_SLEW     12'h518
`define GP_OFF_DIGEN    12'h51C
`define GP_OFF_FUNC     12'h52C

// per-port vectors, port e in the top byte, port a in the low byte
`define GP_IMPL_MASK    40'h033FFFFF3F
`define GP_RST_ALTSEL   40'h00000F003F
`define GP_RST_DIGEN    40'h00000F003F
`define GP_RST_PULLUP   40'h00000F0000
`define GP_RST_PULLDN   40'h0000000000
`define GP_RST_FUNC     160'h0000000000000000000033330000000000111111

// port b bit 4 feeds the converter trigger
`define GP_TRIG_PORT    1
`define GP_TRIG_BIT     4

`endif

/* rtl/gp_pin_irq.v */
// one pin: input synchroniser, digital-enable gate, edge/level detector
`timescale 1ns/100ps
module gp_pin_irq (
    input  wire clk_i,
    input  wire rst_i,
    input  wire pad_i,
    input  wire dig_en_i,
    input  wire sense_lvl_i,
    input  wire both_i,
    input  wire evt_hi_i,
    input  wire clr_i,
    output wire din_o,
    output wire ris_o,
    output wire hit_o
);
    reg  sync_a;
    reg  sync_b;
    reg  prev;
    reg  ris;
    wire gated;
    wire rise;
    wire fall;
    wire edge_hit;

    // RULE_06 digital input disabled
    assign gated = sync_b & dig_en_i;
    assign rise  = gated & ~prev;
    assign fall  = ~gated & prev;
    assign edge_hit = both_i ? (rise | fall) : (evt_hi_i ? rise : fall);
    // RULE_03 trigger kind select
    assign hit_o = sense_lvl_i ? (gated == evt_hi_i) : edge_hit;
    assign din_o = gated;
    assign ris_o = ris;

    // RULE_17 two stage synchroniser
    always @(posedge clk_i) begin
        if (rst_i) begin
            sync_a <= 1'b0;
            sync_b <= 1'b0;
            prev   <= 1'b0;
            ris    <= 1'b0;
        end else begin
            sync_a <= pad_i;
            sync_b <= sync_a;
            prev   <= gated;
            // RULE_15 edge latched until cleared
            if (sense_lvl_i)
                ris <= hit_o;
            else
                ris <= hit_o | (ris & ~clr_i);
        end
    end
endmodule // gp_pin_irq

/* rtl/gp_port_bank.v */
// five-port gpio bank with pin mux, pad control and interrupts on wishbone
`timescale 1ns/100ps
`include "gp_consts.vh"

// Overview of operation
// RULE_01 - five identical ports, thirty pins total
// RULE_02 - output may change every two cycles
// RULE_03 - edge or level interrupt, maskable per pin
// RULE_04 - data access masked by address lines
// RULE_05 - port logic can trigger the converter
// RULE_06 - digital enable low gives pin to analog
// RULE_07 - peripheral needs alt select and enable
// RULE_08 - function select held per pin
// RULE_09 - default pins are tri-stated software pins
// RULE_10 - reset restores every pin default
// RULE_11 - serial and debug pins default to peripheral
// RULE_12 - pulls, drive, open drain, slew at 8mA
// RULE_13 - direction picks capture or drive
// RULE_14 - address bits 9:2 mask data bits
// RULE_15 - one irq per port, edge latched
// RULE_16 - port b bit4 event triggers converter
// RULE_17 - pad inputs pass two flip-flops
// RULE_18 - ports parameterised, absent pins read zero; func_ctl code fields of absent pins keep written values
module gp_port_bank #(
    parameter [`GP_ALLW-1:0]   IMPL_MASK  = `GP_IMPL_MASK,
    parameter [`GP_ALLW-1:0]   RST_ALTSEL = `GP_RST_ALTSEL,
    parameter [`GP_ALLW-1:0]   RST_DIGEN  = `GP_RST_DIGEN,
    parameter [`GP_ALLW-1:0]   RST_PULLUP = `GP_RST_PULLUP,
    parameter [`GP_ALLW-1:0]   RST_PULLDN = `GP_RST_PULLDN,
    parameter [`GP_ALLW*4-1:0] RST_FUNC   = `GP_RST_FUNC
) (
    input  wire                    clk_i,
    input  wire                    rst_i,
    input  wire                    wb_cyc_i,
    input  wire                    wb_stb_i,
    input  wire                    wb_we_i,
    input  wire [`GP_ADR_W-1:0]    wb_adr_i,
    input  wire [3:0]              wb_sel_i,
    input  wire [31:0]             wb_dat_i,
    output reg  [31:0]             wb_dat_o,
    output reg                     wb_ack_o,
    input  wire [`GP_ALLW-1:0]     pad_in_i,
    output wire [`GP_ALLW-1:0]     pad_out_o,
    output wire [`GP_ALLW-1:0]     pad_oe_o,
    output wire [`GP_ALLW-1:0]     pad_pu_o,
    output wire [`GP_ALLW-1:0]     pad_pd_o,
    output wire [`GP_ALLW-1:0]     pad_dr2_o,
    output wire [`GP_ALLW-1:0]     pad_dr4_o,
    output wire [`GP_ALLW-1:0]     pad_dr8_o,
    output wire [`GP_ALLW-1:0]     pad_slr_o,
    output wire [`GP_ALLW-1:0]     pad_od_o,
    output wire [`GP_ALLW-1:0]     pad_dig_en_o,
    output wire [`GP_ALLW-1:0]     pad_ana_o,
    input  wire [`GP_ALLW-1:0]     alt_out_i,
    input  wire [`GP_ALLW-1:0]     alt_oe_i,
    output wire [`GP_ALLW-1:0]     alt_in_o,
    output wire [`GP_ALLW*4-1:0]   func_code_o,
    output wire [`GP_NPORT-1:0]    irq_o,
    output reg                     adc_trig_o
);
    wire        acc;
    wire        wr;
    wire [2:0]  port_sel;
    wire [11:0] off;
    wire        in_data;
    wire [7:0]  bmask;
    wire [7:0]  dmask;
    wire [31:0] wmask;
    wire [31:0] rd_w [0:`GP_NPORT-1];
    wire [`GP_NPORT-1:0] trig_w;
    reg  [31:0] rd_sel;

    function [7:0] gp_upd;
        input [7:0] old;
        input [7:0] d;
        input [7:0] m;
        gp_upd = (old & ~m) | (d & m);
    endfunction

    // a request is taken once; ack drops the next cycle
    assign acc      = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign wr       = acc & wb_we_i;
    assign port_sel = wb_adr_i[`GP_PORT_HI:`GP_PORT_LO];
    assign off      = {wb_adr_i[`GP_OFF_HI:2], 2'b00};
    assign in_data  = (wb_adr_i[11:10] == `GP_DATA_WIN);
    assign bmask    = {8{wb_sel_i[0]}};
    // RULE_04 mask from address
    // RULE_14 address bits 9:2
    assign dmask    = bmask & wb_adr_i[9:2];
    assign wmask    = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, bmask};

    // RULE_01 five identical port blocks
    genvar p;
    genvar b;
    generate
        for (p = 0; p < `GP_NPORT; p = p + 1) begin : g_port
            localparam [7:0]  IMPL = IMPL_MASK[p*8 +: 8];
            wire              wr_p;
            wire [7:0]        din;
            wire [7:0]        ris;
            wire [7:0]        hit;
            wire [7:0]        clr;
            wire [7:0]        out_val;
            wire [7:0]        drv;
            reg  [7:0]        pin_data;
            reg  [7:0]        pin_dir;
            reg  [7:0]        sense_lvl;
            reg  [7:0]        both_edge;
            reg  [7:0]        evt_hi;
            reg  [7:0]        int_mask;
            reg  [7:0]        alt_sel;
            reg  [7:0]        dr2;
            reg  [7:0]        dr4;
            reg  [7:0]        dr8;
            reg  [7:0]        odrain;
            reg  [7:0]        pull_up;
            reg  [7:0]        pull_dn;
            reg  [7:0]        slew;
            reg  [7:0]        dig_en;
            reg  [31:0]       func_ctl;
            reg  [7:0]        pad_out;
            reg  [7:0]        pad_oe;
            reg  [7:0]        slr_eff;
            reg  [7:0]        ana;
            reg  [7:0]        alt_in;
            reg               irq;
            reg  [31:0]       rd;

            assign wr_p = wr & (port_sel == p);
            assign clr  = (wr_p && off == `GP_OFF_ICLR) ? (wb_dat_i[7:0] & bmask) : 8'h00;

            for (b = 0; b < `GP_PW; b = b + 1) begin : g_pin
                gp_pin_irq u_pin (
                    .clk_i       (clk_i),
                    .rst_i       (rst_i),
                    .pad_i       (pad_in_i[p*8+b]),
                    .dig_en_i    (dig_en[b]),
                    .sense_lvl_i (sense_lvl[b]),
                    .both_i      (both_edge[b]),
                    .evt_hi_i    (evt_hi[b]),
                    .clr_i       (clr[b]),
                    .din_o       (din[b]),
                    .ris_o       (ris[b]),
                    .hit_o       (hit[b])
                );
            end

            // RULE_07 peripheral drives only when selected and enabled
            assign out_val = (alt_sel & alt_out_i[p*8 +: 8]) | (~alt_sel & pin_data);
            assign drv     = dig_en & ((alt_sel & alt_oe_i[p*8 +: 8]) | (~alt_sel & pin_dir));

            always @(posedge clk_i) begin
                // RULE_10 every reset restores defaults
                if (rst_i) begin
                    pin_data  <= 8'h00;
                    pin_dir   <= 8'h00;
                    sense_lvl <= 8'h00;
                    both_edge <= 8'h00;
                    evt_hi    <= 8'h00;
                    int_mask  <= 8'h00;
                    // RULE_09 tri-stated software defaults
                    // RULE_11 serial and debug exceptions
                    alt_sel   <= RST_ALTSEL[p*8 +: 8];
                    dig_en    <= RST_DIGEN[p*8 +: 8];
                    pull_up   <= RST_PULLUP[p*8 +: 8];
                    pull_dn   <= RST_PULLDN[p*8 +: 8];
                    func_ctl  <= RST_FUNC[p*32 +: 32];
                    dr2       <= IMPL;
                    dr4       <= 8'h00;
                    dr8       <= 8'h00;
                    odrain    <= 8'h00;
                    slew      <= 8'h00;
                    pad_out   <= 8'h00;
                    pad_oe    <= 8'h00;
                    slr_eff   <= 8'h00;
                    ana       <= IMPL & ~RST_DIGEN[p*8 +: 8];
                    alt_in    <= 8'h00;
                    irq       <= 1'b0;
                end else begin
                    // RULE_13 inputs capture, outputs hold
                    // RULE_02 new value each write
                    if (wr_p && in_data)
                        pin_data <= IMPL & ((pin_dir & gp_upd(pin_data, wb_dat_i[7:0], dmask))
                                            | (~pin_dir & din));
                    else
                        pin_data <= IMPL & ((pin_dir & pin_data) | (~pin_dir & din));
                    if (wr_p) begin
                        case (off)
                            `GP_OFF_DIR:    pin_dir   <= IMPL & gp_upd(pin_dir, wb_dat_i[7:0], bmask);
                            `GP_OFF_ISENSE: sense_lvl <= IMPL & gp_upd(sense_lvl, wb_dat_i[7:0], bmask);
                            `GP_OFF_IBOTH:  both_edge <= IMPL & gp_upd(both_edge, wb_dat_i[7:0], bmask);
                            `GP_OFF_IEVT:   evt_hi    <= IMPL & gp_upd(evt_hi, wb_dat_i[7:0], bmask);
                            `GP_OFF_IMASK:  int_mask  <= IMPL & gp_upd(int_mask, wb_dat_i[7:0], bmask);
                            `GP_OFF_ALTSEL: alt_sel   <= IMPL & gp_upd(alt_sel, wb_dat_i[7:0], bmask);
                            `GP_OFF_ODRAIN: odrain    <= IMPL & gp_upd(odrain, wb_dat_i[7:0], bmask);
                            `GP_OFF_PULLUP: pull_up   <= IMPL & gp_upd(pull_up, wb_dat_i[7:0], bmask);
                            `GP_OFF_PULLDN: pull_dn   <= IMPL & gp_upd(pull_dn, wb_dat_i[7:0], bmask);
                            `GP_OFF_SLEW:   slew      <= IMPL & gp_upd(slew, wb_dat_i[7:0], bmask);
                            `GP_OFF_DIGEN:  dig_en    <= IMPL & gp_upd(dig_en, wb_dat_i[7:0], bmask);
                            // RULE_08 one code field per pin
                            `GP_OFF_FUNC:   func_ctl  <= (func_ctl & ~wmask) | (wb_dat_i & wmask);
                            // RULE_12 one drive strength at a time
                            `GP_OFF_DR2: begin
                                dr2 <= IMPL & (dr2 | (wb_dat_i[7:0] & bmask));
                                dr4 <= dr4 & ~(wb_dat_i[7:0] & bmask);
                                dr8 <= dr8 & ~(wb_dat_i[7:0] & bmask);
                            end
                            `GP_OFF_DR4: begin
                                dr4 <= IMPL & (dr4 | (wb_dat_i[7:0] & bmask));
                                dr2 <= dr2 & ~(wb_dat_i[7:0] & bmask);
                                dr8 <= dr8 & ~(wb_dat_i[7:0] & bmask);
                            end
                            `GP_OFF_DR8: begin
                                dr8 <= IMPL & (dr8 | (wb_dat_i[7:0] & bmask));
                                dr2 <= dr2 & ~(wb_dat_i[7:0] & bmask);
                                dr4 <= dr4 & ~(wb_dat_i[7:0] & bmask);
                            end
                            default: ;
                        endcase
                    end
                    // RULE_12 open drain pulls low only
                    pad_out <= IMPL & out_val & ~odrain;
                    pad_oe  <= IMPL & drv & (~odrain | ~out_val);
                    // RULE_12 slew only with 8mA
                    slr_eff <= slew & dr8;
                    // RULE_06 analog when digital off
                    ana     <= IMPL & ~dig_en;
                    alt_in  <= din & alt_sel;
                    // RULE_15 one combined port interrupt
                    irq     <= |(ris & int_mask);
                end
            end

            // RULE_18 absent pins read zero, except their func_ctl code fields, which are not masked
            always @* begin
                rd = 32'h00000000;
                if (in_data)
                    rd[7:0] = pin_data & wb_adr_i[9:2];
                else begin
                    case (off)
                        `GP_OFF_DIR:    rd[7:0] = pin_dir;
                        `GP_OFF_ISENSE: rd[7:0] = sense_lvl;
                        `GP_OFF_IBOTH:  rd[7:0] = both_edge;
                        `GP_OFF_IEVT:   rd[7:0] = evt_hi;
                        `GP_OFF_IMASK:  rd[7:0] = int_mask;
                        `GP_OFF_RAW:    rd[7:0] = ris & IMPL;
                        `GP_OFF_MSTAT:  rd[7:0] = ris & int_mask;
                        `GP_OFF_ALTSEL: rd[7:0] = alt_sel;
                        `GP_OFF_DR2:    rd[7:0] = dr2;
                        `GP_OFF_DR4:    rd[7:0] = dr4;
                        `GP_OFF_DR8:    rd[7:0] = dr8;
                        `GP_OFF_ODRAIN: rd[7:0] = odrain;
                        `GP_OFF_PULLUP: rd[7:0] = pull_up;
                        `GP_OFF_PULLDN: rd[7:0] = pull_dn;
                        `GP_OFF_SLEW:   rd[7:0] = slew;
                        `GP_OFF_DIGEN:  rd[7:0] = dig_en;
                        `GP_OFF_FUNC:   rd      = func_ctl;
                        default:        rd      = 32'h00000000;
                    endcase
                end
            end

            assign rd_w[p]                 = rd;
            // RULE_16 unmasked pin event
            assign trig_w[p]               = hit[`GP_TRIG_BIT] & int_mask[`GP_TRIG_BIT];
            assign pad_out_o[p*8 +: 8]     = pad_out;
            assign pad_oe_o[p*8 +: 8]      = pad_oe;
            assign pad_pu_o[p*8 +: 8]      = pull_up;
            assign pad_pd_o[p*8 +: 8]      = pull_dn;
            assign pad_dr2_o[p*8 +: 8]     = dr2;
            assign pad_dr4_o[p*8 +: 8]     = dr4;
            assign pad_dr8_o[p*8 +: 8]     = dr8;
            assign pad_slr_o[p*8 +: 8]     = slr_eff;
            assign pad_od_o[p*8 +: 8]      = odrain;
            assign pad_dig_en_o[p*8 +: 8]  = dig_en;
            assign pad_ana_o[p*8 +: 8]     = ana;
            assign alt_in_o[p*8 +: 8]      = alt_in;
            assign func_code_o[p*32 +: 32] = func_ctl;
            assign irq_o[p]                = irq;
        end
    endgenerate

    // unmapped ports read as zero but are still acknowledged
    always @* begin
        if (port_sel < `GP_NPORT)
            rd_sel = rd_w[port_sel];
        else
            rd_sel = 32'h00000000;
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o   <= 1'b0;
            wb_dat_o   <= 32'h00000000;
            adc_trig_o <= 1'b0;
        end else begin
            wb_ack_o <= acc;
            if (acc && !wb_we_i)
                wb_dat_o <= rd_sel;
            // RULE_05 converter start pulse
            adc_trig_o <= trig_w[`GP_TRIG_PORT];
        end
    end
endmodule // gp_port_bank

/* tb/gp_port_properties.sv */
// assertion checker for the gpio bank, bound to its top module
`timescale 1ns/100ps
`include "gp_consts.vh"
module gp_port_props #(
    parameter [`GP_ALLW-1:0] IMPL_MASK  = `GP_IMPL_MASK,
    parameter [`GP_ALLW-1:0] RST_DIGEN  = `GP_RST_DIGEN,
    parameter [`GP_ALLW-1:0] RST_PULLUP = `GP_RST_PULLUP
) (
    input wire                 clk_i,
    input wire                 rst_i,
    input wire                 wb_cyc_i,
    input wire                 wb_stb_i,
    input wire                 wb_we_i,
    input wire [`GP_ADR_W-1:0] wb_adr_i,
    input wire [31:0]          wb_dat_o,
    input wire                 wb_ack_o,
    input wire [`GP_ALLW-1:0]  pad_oe_o,
    input wire [`GP_ALLW-1:0]  pad_pu_o,
    input wire [`GP_ALLW-1:0]  pad_dr2_o,
    input wire [`GP_ALLW-1:0]  pad_dr4_o,
    input wire [`GP_ALLW-1:0]  pad_dr8_o,
    input wire [`GP_ALLW-1:0]  pad_slr_o,
    input wire [`GP_ALLW-1:0]  pad_dig_en_o,
    input wire [`GP_ALLW-1:0]  pad_ana_o,
    input wire [`GP_ALLW-1:0]  alt_in_o,
    input wire [`GP_NPORT-1:0] irq_o,
    input wire                 adc_trig_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    property p_ack_next; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
    a_ack_next: assert property (p_ack_next) else $error("request not answered");
    property p_ack_cause; wb_ack_o |-> $past(wb_cyc_i && wb_stb_i) && !$past(wb_ack_o); endproperty
    a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
    // registered config lags the register by one edge, so only compare when settled
    property p_analog;
        !$past(rst_i) && $stable(pad_dig_en_o) |-> pad_ana_o == (IMPL_MASK & ~pad_dig_en_o);
    endproperty
    a_analog: assert property (p_analog) else $error("analog select wrong");
    property p_alt_in;
        !$past(rst_i) && $stable(pad_dig_en_o) |-> (alt_in_o & ~(pad_dig_en_o & IMPL_MASK)) == 0;
    endproperty
    a_alt_in: assert property (p_alt_in) else $error("peripheral input not gated");
    property p_rst_state;
        disable iff (1'b0) rst_i |=> pad_oe_o == 0 && irq_o == 0 && !wb_ack_o && !adc_trig_o
            && pad_dig_en_o == RST_DIGEN && pad_pu_o == RST_PULLUP && pad_dr2_o == IMPL_MASK;
    endproperty
    a_rst_state: assert property (p_rst_state) else $error("reset state wrong");
    property p_slew; !$past(rst_i) && $stable(pad_dr8_o) |-> (pad_slr_o & ~pad_dr8_o) == 0; endproperty
    a_slew: assert property (p_slew) else $error("slew without strong drive");
    property p_drive_one;
        ((pad_dr2_o & pad_dr4_o) | (pad_dr2_o & pad_dr8_o) | (pad_dr4_o & pad_dr8_o)) == 0;
    endproperty
    a_drive_one: assert property (p_drive_one) else $error("two drive strengths");
    property p_rd_mask;
        wb_ack_o && !$past(wb_we_i) && $past(wb_adr_i[11:10]) == `GP_DATA_WIN
            |-> (wb_dat_o & ~{24'h000000, $past(wb_adr_i[9:2])}) == 32'h00000000;
    endproperty
    a_rd_mask: assert property (p_rd_mask) else $error("masked data bit read");
    property p_rd_width;
        wb_ack_o && !$past(wb_we_i) && $past(wb_adr_i[11:0]) != `GP_OFF_FUNC
            |-> wb_dat_o[31:8] == 24'h000000;
    endproperty
    a_rd_width: assert property (p_rd_width) else $error("upper read bits set");
    property p_trig_irq; adc_trig_o |-> ##[0:2] irq_o[`GP_TRIG_PORT]; endproperty
    a_trig_irq: assert property (p_trig_irq) else $error("trigger without port irq");
endmodule // gp_port_props

bind gp_port_bank gp_port_props #(.IMPL_MASK(IMPL_MASK), .RST_DIGEN(RST_DIGEN),
    .RST_PULLUP(RST_PULLUP)) props_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .pad_oe_o(pad_oe_o), .pad_pu_o(pad_pu_o), .pad_dr2_o(pad_dr2_o),
    .pad_dr4_o(pad_dr4_o), .pad_dr8_o(pad_dr8_o), .pad_slr_o(pad_slr_o),
    .pad_dig_en_o(pad_dig_en_o), .pad_ana_o(pad_ana_o), .alt_in_o(alt_in_o),
    .irq_o(irq_o), .adc_trig_o(adc_trig_o));

/* tb/gp_pad_model.sv */
// pad-side model: driven pins loop back, test levels otherwise, pulls or noise when floating
`timescale 1ns/100ps
`include "gp_consts.vh"
module gp_pad_model (
    input  wire                clk_i,
    input  wire [`GP_ALLW-1:0] out_i,
    input  wire [`GP_ALLW-1:0] oe_i,
    input  wire [`GP_ALLW-1:0] pu_i,
    input  wire [`GP_ALLW-1:0] pd_i,
    input  wire [`GP_ALLW-1:0] drv_en_i,
    input  wire [`GP_ALLW-1:0] drv_val_i,
    output wire [`GP_ALLW-1:0] pad_o
);
    // floating pins wander so a settled unknown never passes for a level
    reg [`GP_ALLW-1:0] noise = {`GP_ALLW{1'b0}};
    always @(posedge clk_i) noise <= ~noise;
    assign pad_o = (oe_i & out_i) | (~oe_i & drv_en_i & drv_val_i)
                 | (~oe_i & ~drv_en_i & (pu_i | (~pd_i & noise)));
endmodule // gp_pad_model

/* tb/test_gp_port_bank.sv */
// self-checking bench for the five-port gpio bank
`timescale 1ns/100ps
`include "gp_consts.vh"
module test_gp_port_bank;
    logic         clk_i   = 1'b0;
    logic         rst_i   = 1'b1;
    logic         cyc     = 1'b0;
    logic         stb     = 1'b0;
    logic         we      = 1'b0;
    logic [15:0]  adr     = 16'h0000;
    logic [3:0]   sel     = 4'h0;
    logic [31:0]  dat_w   = 32'h00000000;
    logic [39:0]  alt_out = 40'h0000000000;
    logic [39:0]  alt_oe  = 40'h0000000000;
    logic [39:0]  drv_en  = 40'h00FF00FF00;
    logic [39:0]  drv_val = 40'h0000000000;
    wire  [31:0]  dat_r;
    wire          ack;
    wire  [39:0]  pad_in, pad_out, pad_oe, pad_pu, pad_pd, pad_slr, dr2, dr8, ana, alt_in, od;
    wire  [159:0] func;
    wire  [4:0]   irq;
    wire          trig;
    int           err_total = 0;
    int           tests_run = 0;
    logic [3:0]   modes [5] = '{4'h2, 4'h1, 4'h5, 4'hA, 4'h9};

    always #10 clk_i = ~clk_i;

    gp_port_bank dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat_w), .wb_dat_o(dat_r),
        .wb_ack_o(ack), .pad_in_i(pad_in), .pad_out_o(pad_out), .pad_oe_o(pad_oe),
        .pad_pu_o(pad_pu), .pad_pd_o(pad_pd), .pad_dr2_o(dr2), .pad_dr4_o(),
        .pad_dr8_o(dr8), .pad_slr_o(pad_slr), .pad_od_o(od), .pad_dig_en_o(), .pad_ana_o(ana),
        .alt_out_i(alt_out), .alt_oe_i(alt_oe), .alt_in_o(alt_in), .func_code_o(func),
        .irq_o(irq), .adc_trig_o(trig));
    gp_pad_model pm_u (.clk_i(clk_i), .out_i(pad_out), .oe_i(pad_oe), .pu_i(pad_pu),
        .pd_i(pad_pd), .drv_en_i(drv_en), .drv_val_i(drv_val), .pad_o(pad_in));

    task give_verdict;
        $display("comparisons %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task chk(input string what, input logic [39:0] seen, input logic [39:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_total++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task xfer(input logic w, input int p, input logic [11:0] o, input logic [31:0] d,
              output logic [31:0] q);
        int n;
        @(posedge clk_i);
        cyc <= 1'b1; stb <= 1'b1; we <= w; sel <= 4'hF; dat_w <= d;
        adr <= {1'b0, p[2:0], o};
        n = 0;
        do begin @(posedge clk_i); n++; end while (ack !== 1'b1 && n < 20);
        q = dat_r;
        if (n >= 20) begin err_total++; give_verdict; end
        else begin cyc <= 1'b0; stb <= 1'b0; end
    endtask
    task wr(input int p, input logic [11:0] o, input logic [31:0] d);
        logic [31:0] q;
        xfer(1'b1, p, o, d, q);
    endtask
    task rd(input int p, input logic [11:0] o, input logic [31:0] e);
        logic [31:0] q;
        xfer(1'b0, p, o, 32'h00000000, q);
        chk($sformatf("read p%0d o%h", p, o), q, e);
    endtask
    task pin(input int i, input logic v);
        @(posedge clk_i);
        drv_val[i] <= v;
        repeat (5) @(posedge clk_i);
    endtask

    task t_reset;
        rd(0, `GP_OFF_ALTSEL, 32'h3F);
        rd(2, `GP_OFF_ALTSEL, 32'h0F);
        rd(2, `GP_OFF_PULLUP, 32'h0F);
        rd(0, `GP_OFF_FUNC, 32'h00111111);
        rd(2, `GP_OFF_FUNC, 32'h00003333);
        rd(1, `GP_OFF_DIGEN, 32'h00);
        rd(3, `GP_OFF_FUNC, 32'h00);
        rd(1, 12'h600, 32'h00);
        rd(5, `GP_OFF_DIR, 32'h00);
        chk("pad_pd", pad_pd, 40'h0);
        $display("reset done");
    endtask
    task t_alt;
        @(posedge clk_i);
        alt_oe <= 40'hFFFFFFFFFF; alt_out <= 40'h000000002A;
        repeat (8) @(posedge clk_i);
        chk("alt drive", {pad_oe[5:0], pad_out[5:0]}, 12'hFEA);
        chk("alt input", alt_in[5:0], 6'h2A);
        wr(0, `GP_OFF_FUNC, 32'h00000005);
        wr(0, `GP_OFF_DIGEN, 32'h3E);
        repeat (5) @(posedge clk_i);
        chk("code", func[7:0], 8'h05);
        chk("pin0 analog", {pad_oe[0], alt_in[0], ana[0]}, 3'b001);
        $display("alt done");
    endtask
    task t_out;
        wr(1, `GP_OFF_DIGEN, 32'hFF);
        wr(1, `GP_OFF_DIR, 32'hFF);
        wr(1, 12'h3FC, 32'hA5);
        wr(1, 12'h098, 32'hEB);
        @(posedge clk_i);
        chk("out", {pad_oe[15:8], pad_out[15:8]}, 16'hFFA3);
        rd(1, 12'h0C4, 32'h21);
        for (int i = 0; i < 4; i++) begin
            wr(1, 12'h040, {27'h0, i[0], 4'h0});
            @(posedge clk_i);
            chk("toggle", pad_out[12], i[0]);
        end
        wr(1, `GP_OFF_DR8, 32'h01);
        wr(1, `GP_OFF_SLEW, 32'h01);
        wr(1, `GP_OFF_ODRAIN, 32'h01);
        @(posedge clk_i);
        chk("drive", {dr2[8], dr8[8], pad_slr[8], od[8], pad_oe[8]}, 5'b01110);
        wr(1, `GP_OFF_DIR, 32'h00);
        @(posedge clk_i);
        chk("released", pad_oe[15:8], 8'h00);
        $display("output path done");
    endtask
    task t_in;
        wr(3, `GP_OFF_DIGEN, 32'h3F);
        pin(25, 1'b1);
        pin(27, 1'b1);
        rd(3, 12'h3FC, 32'h0A);
        wr(4, `GP_OFF_DIGEN, 32'hFF);
        rd(4, `GP_OFF_DIGEN, 32'h03);
        wr(3, `GP_OFF_DIGEN, 32'h00);
        repeat (4) @(posedge clk_i);
        chk("analog d", ana[31:24], 8'h3F);
        rd(3, 12'h3FC, 32'h00);
        $display("input path done");
    endtask
    task t_irq;
        bit hit;
        wr(1, `GP_OFF_IEVT, 32'h10);
        wr(1, `GP_OFF_IMASK, 32'h10);
        wr(1, `GP_OFF_ICLR, 32'hFF);
        hit = 0;
        @(posedge clk_i);
        drv_val[12] <= 1'b1;
        repeat (6) begin @(posedge clk_i); if (trig === 1'b1) hit = 1; end
        chk("trigger", hit, 1'b1);
        chk("irq b", irq, 5'h02);
        rd(1, `GP_OFF_MSTAT, 32'h10);
        rd(1, `GP_OFF_ICLR, 32'h00);
        wr(1, `GP_OFF_ICLR, 32'h10);
        repeat (2) @(posedge clk_i);
        chk("irq cleared", irq, 5'h00);
        wr(1, `GP_OFF_IMASK, 32'h00);
        pin(12, 1'b0);
        pin(12, 1'b1);
        rd(1, `GP_OFF_RAW, 32'h10);
        chk("masked irq", irq, 5'h00);
        $display("irq done");
    endtask
    task t_modes;
        logic [3:0] m;
        for (int i = 0; i < 5; i++) begin
            m = modes[i];
            pin(10, m[0]);
            wr(1, `GP_OFF_ISENSE, {29'h0, m[3], 2'h0});
            wr(1, `GP_OFF_IBOTH, {29'h0, m[2], 2'h0});
            wr(1, `GP_OFF_IEVT, {29'h0, m[1], 2'h0});
            wr(1, `GP_OFF_ICLR, 32'hFF);
            rd(1, `GP_OFF_RAW, 32'h00);
            pin(10, ~m[0]);
            rd(1, `GP_OFF_RAW, 32'h04);
            pin(10, m[0]);
            rd(1, `GP_OFF_RAW, m[3] ? 32'h00 : 32'h04);
        end
        $display("trigger modes done");
    endtask

    initial begin
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset;
        t_alt;
        t_out;
        t_in;
        t_irq;
        t_modes;
        // a second reset mid-run must bring every default back
        @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset;
        give_verdict;
    end
endmodule // test_gp_port_bank
